// ---- design/pcsc_regs.vh ----
// Constants for the process channel state control block
`ifndef PCSC_REGS_VH
`define PCSC_REGS_VH

// ----------------------------------------------------------------
// Source selection codes
// ----------------------------------------------------------------
`define PCSC_SRC_PRESS   2'h0
`define PCSC_SRC_ANALOG  2'h1
`define PCSC_SRC_CLOCK   2'h2
`define PCSC_SRC_TTL     2'h3

// ----------------------------------------------------------------
// Manual command codes and reset values
// ----------------------------------------------------------------
`define PCSC_CMD_NONE    2'h0
`define PCSC_CMD_INACT   2'h1
`define PCSC_CMD_ACT     2'h2
`define PCSC_CMD_AUTO    2'h3
`define PCSC_RST_AUTO    1'h0
`define PCSC_RST_STATE   1'h0

// ----------------------------------------------------------------
// Remote input bit positions
// ----------------------------------------------------------------
`define PCSC_RC_REMOTE   0
`define PCSC_RC_FIL      1
`define PCSC_RC_DEGAS    2
`define PCSC_RC_LOCKOUT  3
`define PCSC_RC_KEYDIS   4
`define PCSC_RC_LOGRST   5
`define PCSC_RC_TOUCHDIS 6
`define PCSC_RC_COUNT    7

// ----------------------------------------------------------------
// Timing: delay unit in microseconds, clock in MHz
// ----------------------------------------------------------------
`define PCSC_DELAY_UNIT_US 1000
`define PCSC_CLK_MHZ       10
`define PCSC_TICK_CYCLES   (`PCSC_DELAY_UNIT_US * `PCSC_CLK_MHZ)

`endif

// ---- design/pcsc_channel.v ----
// One process control channel: rule evaluation, delay and override
`timescale 1ns/1ps
module pcsc_channel
#(
   parameter VW = 16,
   parameter DW = 16
)
(
   input  wire          clk_i,
   input  wire          rstn_i,
   input  wire          tick_i,
   input  wire [1:0]    src_sel_i,
   input  wire [VW-1:0] level_i,
   input  wire          polarity_i,
   input  wire [VW-1:0] hyst_i,
   input  wire [DW-1:0] delay_i,
   input  wire          fallback_i,
   input  wire [VW-1:0] meas_i,
   input  wire          meas_bad_i,
   input  wire          meas_freeze_i,
   input  wire          clock_in_i,
   input  wire          ttl_in_i,
   input  wire [1:0]    cmd_i,
   output reg           auto_o,
   output reg           state_o,
   output wire          change_o
);

`include "pcsc_regs.vh"

   reg  [DW-1:0] dcount;
   reg           next_state;
   reg           target;
   reg           hold;
   reg  [VW:0]   up_lim;
   reg  [VW:0]   lo_lim;
   wire          meas_src;

   assign meas_src = (src_sel_i == `PCSC_SRC_PRESS) ||
                     (src_sel_i == `PCSC_SRC_ANALOG);

   // ----------------------------------------------------------------
   // Rule target with hysteresis band
   // ----------------------------------------------------------------
   always @*
   begin
      hold   = 1'b0;
      target = state_o;
      up_lim = {1'b0, level_i} + {1'b0, hyst_i};
      lo_lim = {1'b0, level_i} - {1'b0, hyst_i};
      if (meas_src)
      begin
         if (meas_freeze_i)
            hold = 1'b1;
         else if (meas_bad_i)
            target = fallback_i;
         else if (polarity_i)
         begin
            // Active above level, release only below level - hysteresis
            if (meas_i > level_i)
               target = 1'b1;
            else if ({1'b0, meas_i} < lo_lim || level_i < hyst_i)
               target = (level_i < hyst_i) ? state_o : 1'b0;
         end
         else
         begin
            if (meas_i < level_i)
               target = 1'b1;
            else if ({1'b0, meas_i} > up_lim)
               target = 1'b0;
         end
      end
      else if (src_sel_i == `PCSC_SRC_CLOCK)
         target = clock_in_i ^ ~polarity_i;
      else
         target = ttl_in_i ^ ~polarity_i;
   end

   // ----------------------------------------------------------------
   // Mode, delay counter and state
   // ----------------------------------------------------------------
   always @*
   begin
      next_state = state_o;
      if (cmd_i == `PCSC_CMD_ACT)
         next_state = 1'b1;
      else if (cmd_i == `PCSC_CMD_INACT)
         next_state = 1'b0;
      else if (auto_o && !hold && target != state_o &&
               dcount >= delay_i && tick_i)
         next_state = target;
      else if (auto_o && !hold && target != state_o && delay_i == 0)
         next_state = target;
   end

   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         auto_o  <= `PCSC_RST_AUTO;
         state_o <= `PCSC_RST_STATE;
         dcount  <= {DW{1'b0}};
      end
      else
      begin
         state_o <= next_state;
         if (cmd_i == `PCSC_CMD_AUTO)
            auto_o <= 1'b1;
         else if (cmd_i != `PCSC_CMD_NONE)
            auto_o <= 1'b0;
         // Delay restarts whenever the condition drops out
         if (!auto_o || target == state_o || next_state != state_o)
            dcount <= {DW{1'b0}};
         else if (tick_i && !hold && dcount != {DW{1'b1}})
            dcount <= dcount + 1'b1;
      end
   end

   assign change_o = (next_state != state_o);

endmodule // pcsc_channel

// ---- design/pcsc_top.v ----
// Eight-channel process control with outputs, freeze and event log
`timescale 1ns/1ps
// Needed before the header: the tick count default comes from it
`include "pcsc_regs.vh"
module pcsc_top
#(
   parameter NCH        = 8,
   parameter VW         = 16,
   parameter DW         = 16,
   parameter TW         = 32,
   parameter LOG_DEPTH  = 16,
   parameter LAW        = 4,
   parameter TICK_COUNT = `PCSC_TICK_CYCLES
)
(
   input  wire                 clk_i,
   input  wire                 rstn_i,
   input  wire [2*NCH-1:0]     src_sel_i,
   input  wire [NCH*VW-1:0]    level_i,
   input  wire [NCH-1:0]       polarity_i,
   input  wire [NCH*VW-1:0]    hyst_i,
   input  wire [NCH*DW-1:0]    delay_i,
   input  wire [NCH-1:0]       fallback_i,
   input  wire [NCH*VW-1:0]    meas_i,
   input  wire [NCH-1:0]       meas_bad_i,
   input  wire [NCH-1:0]       meas_partial_i,
   input  wire [NCH-1:0]       clock_in_i,
   input  wire [NCH-1:0]       ttl_in_i,
   input  wire [2*NCH-1:0]     panel_cmd_i,
   input  wire [2*NCH-1:0]     host_cmd_i,
   input  wire                 gas_analyzer_head_emission_i,
   input  wire                 gas_analyzer_head_degas_i,
   input  wire                 spectrum_scan_view_i,
   input  wire [6:0]           remote_in_n_i,
   input  wire [LAW-1:0]       log_rd_addr_i,
   output reg  [NCH-1:0]       relay_o,
   output reg  [NCH-1:0]       ttl_out_o,
   output reg  [NCH-1:0]       lamp_o,
   output wire [NCH-1:0]       auto_o,
   output reg                  remote_enable_o,
   output reg                  filament_on_o,
   output reg                  degas_on_o,
   output reg                  filament_lockout_o,
   output reg                  keypad_disable_o,
   output reg                  touch_disable_o,
   output reg  [TW-1:0]        log_time_o,
   output reg  [NCH-1:0]       log_state_o,
   output reg  [LAW:0]         log_count_o,
   output reg  [TW-1:0]        time_o
);

   localparam [LAW:0] LOG_FULL = LOG_DEPTH;

   wire [NCH-1:0]  state;
   wire [NCH-1:0]  change;
   wire            busy;
   wire            log_clear;
   reg  [23:0]     tick_cnt;
   reg             tick;
   reg  [LAW-1:0]  log_wr;
   reg  [TW-1:0]   log_time_mem  [0:LOG_DEPTH-1];
   reg  [NCH-1:0]  log_state_mem [0:LOG_DEPTH-1];

   // ----------------------------------------------------------------
   // Analyzer busy and freeze
   // ----------------------------------------------------------------
   assign busy = gas_analyzer_head_emission_i |
                 gas_analyzer_head_degas_i | spectrum_scan_view_i;

   // Host command wins over panel when both arrive together
   function [1:0] pick_cmd;
      input [1:0] host;
      input [1:0] panel;
      begin
         pick_cmd = (host != `PCSC_CMD_NONE) ? host : panel;
      end
   endfunction

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1)
      begin : g_ch
         pcsc_channel
         #(
            .VW (VW),
            .DW (DW)
         )
         u_ch
         (
            .clk_i         (clk_i),
            .rstn_i        (rstn_i),
            .tick_i        (tick),
            .src_sel_i     (src_sel_i[2*g+1:2*g]),
            .level_i       (level_i[VW*g+VW-1:VW*g]),
            .polarity_i    (polarity_i[g]),
            .hyst_i        (hyst_i[VW*g+VW-1:VW*g]),
            .delay_i       (delay_i[DW*g+DW-1:DW*g]),
            .fallback_i    (fallback_i[g]),
            .meas_i        (meas_i[VW*g+VW-1:VW*g]),
            .meas_bad_i    (meas_bad_i[g]),
            .meas_freeze_i (meas_partial_i[g] & busy),
            .clock_in_i    (clock_in_i[g]),
            .ttl_in_i      (ttl_in_i[g]),
            .cmd_i         (pick_cmd(host_cmd_i[2*g+1:2*g],
                                     panel_cmd_i[2*g+1:2*g])),
            .auto_o        (auto_o[g]),
            .state_o       (state[g]),
            .change_o      (change[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Channel outputs, registered
   // ----------------------------------------------------------------
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         relay_o   <= {NCH{1'b0}};
         ttl_out_o <= {NCH{1'b1}};
         lamp_o    <= {NCH{1'b0}};
      end
      else
      begin
         relay_o   <= state;
         ttl_out_o <= ~state;
         lamp_o    <= state;
      end
   end

   // ----------------------------------------------------------------
   // Delay tick and time stamp counter
   // ----------------------------------------------------------------
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         tick_cnt <= 24'h000000;
         tick     <= 1'b0;
         time_o   <= {TW{1'b0}};
      end
      else
      begin
         time_o <= time_o + 1'b1;
         if (tick_cnt >= TICK_COUNT - 1)
         begin
            tick_cnt <= 24'h000000;
            tick     <= 1'b1;
         end
         else
         begin
            tick_cnt <= tick_cnt + 1'b1;
            tick     <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Remote-control inputs, isolated and active low at the pins
   // ----------------------------------------------------------------
   assign log_clear = ~remote_in_n_i[`PCSC_RC_LOGRST];

   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         remote_enable_o    <= 1'b0;
         filament_on_o      <= 1'b0;
         degas_on_o         <= 1'b0;
         filament_lockout_o <= 1'b0;
         keypad_disable_o   <= 1'b0;
         touch_disable_o    <= 1'b0;
      end
      else
      begin
         remote_enable_o    <= ~remote_in_n_i[`PCSC_RC_REMOTE];
         filament_on_o      <= ~remote_in_n_i[`PCSC_RC_FIL];
         degas_on_o         <= ~remote_in_n_i[`PCSC_RC_DEGAS];
         filament_lockout_o <= ~remote_in_n_i[`PCSC_RC_LOCKOUT];
         keypad_disable_o   <= ~remote_in_n_i[`PCSC_RC_KEYDIS];
         touch_disable_o    <= ~remote_in_n_i[`PCSC_RC_TOUCHDIS];
      end
   end

   // ----------------------------------------------------------------
   // Event log: circular, oldest entries overwritten when full
   // ----------------------------------------------------------------
   always @(posedge clk_i)
   begin
      if (|change)
      begin
         log_time_mem[log_wr]  <= time_o;
         log_state_mem[log_wr] <= state ^ change;
      end
   end

   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         log_wr      <= {LAW{1'b0}};
         log_count_o <= {(LAW+1){1'b0}};
         log_time_o  <= {TW{1'b0}};
         log_state_o <= {NCH{1'b0}};
      end
      else
      begin
         // A new event in the clear cycle restarts the count at one but is stored at the old write address
         if (|change)
         begin
            log_wr <= log_clear ? {{(LAW-1){1'b0}}, 1'b1} :
                      log_wr + 1'b1;
            if (log_clear)
               log_count_o <= {{LAW{1'b0}}, 1'b1};
            else if (log_count_o != LOG_FULL)
               log_count_o <= log_count_o + 1'b1;
         end
         else if (log_clear)
         begin
            log_wr      <= {LAW{1'b0}};
            log_count_o <= {(LAW+1){1'b0}};
         end
         log_time_o  <= log_time_mem[log_rd_addr_i];
         log_state_o <= log_state_mem[log_rd_addr_i];
      end
   end

endmodule // pcsc_top

// ---- tb/pcsc_checker.sv ----
// Concurrent assertions on the process channel block ports
`timescale 1ns/1ps
module pcsc_checker
#(
   parameter NCH = 8,
   parameter TW  = 32
)
(
   input wire             clk_i,
   input wire             rstn_i,
   input wire [2*NCH-1:0] host_cmd_i,
   input wire [2*NCH-1:0] panel_cmd_i,
   input wire [NCH-1:0]   meas_partial_i,
   input wire             spectrum_scan_view_i,
   input wire [6:0]       remote_in_n_i,
   input wire [NCH-1:0]   relay_o,
   input wire [NCH-1:0]   ttl_out_o,
   input wire [NCH-1:0]   lamp_o,
   input wire [NCH-1:0]   auto_o,
   input wire             remote_enable_o,
   input wire             keypad_disable_o,
   input wire [TW-1:0]    time_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Auto mode may lag its command by one register stage
   wire auto_cmd = host_cmd_i[1:0] == 2'h3 ||
                   (host_cmd_i[1:0] == 2'h0 && panel_cmd_i[1:0] == 2'h3);
   reg  ac1, ac2;
   always @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         {ac1, ac2} <= 2'h0;
      else
         {ac1, ac2} <= {auto_cmd, ac1};
   sequence s_host_act;
      host_cmd_i[1:0] == 2'h2;
   endsequence
   sequence s_drive_on;
      !auto_o[0] ##1 relay_o[0];
   endsequence
   property p_host_act;
      s_host_act |=> s_drive_on;
   endproperty
   property p_panel_off;
      panel_cmd_i[1:0] == 2'h1 && host_cmd_i[1:0] == 2'h0 |=> ##1 !relay_o[0];
   endproperty
   property p_ttl;
      ttl_out_o == ~relay_o;
   endproperty
   property p_lamp;
      lamp_o == relay_o;
   endproperty
   property p_power_on;
      !$past(rstn_i) |-> relay_o == 0 && auto_o == 0;
   endproperty
   property p_auto_cause;
      $rose(auto_o[0]) |-> ac1 || ac2;
   endproperty
   property p_remote;
      $past(rstn_i) |-> remote_enable_o == !$past(remote_in_n_i[0]) &&
                        keypad_disable_o == !$past(remote_in_n_i[4]);
   endproperty
   property p_freeze;
      spectrum_scan_view_i && meas_partial_i[5] && auto_o[5] &&
      host_cmd_i[11:10] == 2'h0 && panel_cmd_i[11:10] == 2'h0
      |-> ##1 $stable(relay_o[5]);
   endproperty
   property p_time;
      $past(rstn_i) |-> time_o == $past(time_o) + 1'b1;
   endproperty
   a_host_act: assert property (p_host_act)
      else $error("host activate not driven");
   a_panel_off: assert property (p_panel_off)
      else $error("panel deactivate not driven");
   a_ttl: assert property (p_ttl)
      else $error("ttl output not inverse of relay");
   a_lamp: assert property (p_lamp)
      else $error("lamp differs from relay");
   a_power_on: assert property (p_power_on)
      else $error("channels not manual inactive after reset");
   a_auto_cause: assert property (p_auto_cause)
      else $error("auto mode without command");
   a_remote: assert property (p_remote)
      else $error("remote input not mirrored");
   a_freeze: assert property (p_freeze)
      else $error("frozen channel changed");
   a_time: assert property (p_time)
      else $error("time stamp counter skipped");
endmodule // pcsc_checker

bind pcsc_top pcsc_checker #(.NCH(NCH), .TW(TW)) u_chk
(
   .clk_i(clk_i), .rstn_i(rstn_i), .host_cmd_i(host_cmd_i),
   .panel_cmd_i(panel_cmd_i), .meas_partial_i(meas_partial_i),
   .spectrum_scan_view_i(spectrum_scan_view_i),
   .remote_in_n_i(remote_in_n_i), .relay_o(relay_o), .ttl_out_o(ttl_out_o),
   .lamp_o(lamp_o), .auto_o(auto_o), .remote_enable_o(remote_enable_o),
   .keypad_disable_o(keypad_disable_o), .time_o(time_o)
);

// ---- tb/pcsc_plant.sv ----
// Model of the valves and TTL gear wired to the channel outputs
`timescale 1ns/1ps
module pcsc_plant
#(
   parameter NCH  = 8,
   parameter SLOW = 1
)
(
   input  wire           clk_i,
   input  wire [NCH-1:0] relay_i,
   input  wire [NCH-1:0] ttl_n_i,
   input  wire [NCH-1:0] sensor_i,
   output wire [NCH-1:0] valve_open_o,
   output wire [NCH-1:0] ttl_in_o,
   output wire [NCH-1:0] clash_o
);
   reg [NCH-1:0] p1 = {NCH{1'h0}};
   reg [NCH-1:0] p2 = {NCH{1'h0}};
   // Valve on the N.O. contact opens only while the relay is energized
   assign valve_open_o = relay_i;
   // Energized relay with a high TTL line means the pair disagrees
   assign clash_o = relay_i & ttl_n_i;
   // Slow gear answers two cycles late, exposing any early sampling
   assign ttl_in_o = SLOW ? p2 : sensor_i;
   always @(posedge clk_i)
   begin
      p1 <= sensor_i;
      p2 <= p1;
   end
endmodule // pcsc_plant

// ---- tb/test_pcsc_top.sv ----
// Self-checking bench for the eight-channel process control block
`timescale 1ns/1ps
`include "pcsc_regs.vh"
`define CHK(a, e) begin n_tests = n_tests + 1; if ((a) !== (e)) begin \
   errors = errors + 1; $display("ERROR %0t got %0h exp %0h", $time, \
   a, e); end end
module test_pcsc_top;
   reg          clk_i = 1'h0;
   reg          rstn_i = 1'h0;
   reg  [15:0]  src_sel = 16'h0, pcmd = 16'h0, hcmd = 16'h0;
   reg  [127:0] level = 128'h0, hyst = 128'h0, delay = 128'h0;
   reg  [127:0] meas = 128'h0;
   reg  [7:0]   pol = 8'h0, fb = 8'h0, bad = 8'h0, part = 8'h0;
   reg  [7:0]   clk_src = 8'h0, sens = 8'h0;
   reg          emis = 1'h0, degas = 1'h0, scan = 1'h0;
   reg  [6:0]   rin_n = 7'h7F;
   reg  [3:0]   raddr = 4'h0;
   wire [7:0]   relay, ttl_out, lamp, auto, lstate, valve, ttl_in, clash;
   wire [4:0]   lcount;
   wire [31:0]  ltime;
   reg  [31:0]  lt_prev = 32'h0;
   wire [5:0]   rc;
   integer      errors = 0, n_tests = 0, cyc = 0, i;

   pcsc_top #(.TICK_COUNT(4)) uut
   (
      .clk_i(clk_i), .rstn_i(rstn_i), .src_sel_i(src_sel), .level_i(level),
      .polarity_i(pol), .hyst_i(hyst), .delay_i(delay), .fallback_i(fb),
      .meas_i(meas), .meas_bad_i(bad), .meas_partial_i(part),
      .clock_in_i(clk_src), .ttl_in_i(ttl_in), .panel_cmd_i(pcmd),
      .host_cmd_i(hcmd), .gas_analyzer_head_emission_i(emis),
      .gas_analyzer_head_degas_i(degas), .spectrum_scan_view_i(scan),
      .remote_in_n_i(rin_n), .log_rd_addr_i(raddr), .relay_o(relay),
      .ttl_out_o(ttl_out), .lamp_o(lamp), .auto_o(auto),
      .remote_enable_o(rc[0]), .filament_on_o(rc[1]), .degas_on_o(rc[2]),
      .filament_lockout_o(rc[3]), .keypad_disable_o(rc[4]),
      .touch_disable_o(rc[5]), .log_time_o(ltime), .log_state_o(lstate),
      .log_count_o(lcount), .time_o()
   );
   pcsc_plant #(.NCH(8), .SLOW(1)) u_plant
   (
      .clk_i(clk_i), .relay_i(relay), .ttl_n_i(ttl_out), .sensor_i(sens),
      .valve_open_o(valve), .ttl_in_o(ttl_in), .clash_o(clash)
   );

   // ----------------------------------------------------------------
   // Clock, timeout and access tasks
   // ----------------------------------------------------------------
   initial
      forever #50 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         errors = errors + 1;
         end_of_test;
      end
   end
   task tick(input integer n);
      repeat (n) @(negedge clk_i);
   endtask
   // One-cycle command strobe, then wait until the outputs follow
   task raw(input [15:0] h, input [15:0] p);
      @(negedge clk_i);
      hcmd = h;
      pcmd = p;
      @(negedge clk_i);
      {hcmd, pcmd} = 32'h0;
      @(negedge clk_i);
   endtask
   task chk_ch(input integer ch, input s);
      `CHK({relay[ch], ttl_out[ch], lamp[ch], valve[ch]},
           {s, ~s, s, s})
      `CHK(clash, 8'h0)
   endtask
   task setup(input integer ch, input [1:0] s, input p, input [15:0] lv,
              input [15:0] hy, input [15:0] dl);
      src_sel[2*ch +: 2] = s;
      pol[ch] = p;
      level[16*ch +: 16] = lv;
      hyst[16*ch +: 16] = hy;
      delay[16*ch +: 16] = dl;
      raw(16'h3 << 2*ch, 16'h0);
   endtask
   task mstep(input integer ch, input [15:0] v, input s);
      meas[16*ch +: 16] = v;
      tick(4);
      chk_ch(ch, s);
   endtask
   task end_of_test;
      $display("Comparisons %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      tick(4);
      rstn_i = 1'h1;
      tick(1);
      for (i = 0; i < 8; i = i + 1)
         chk_ch(i, 1'h0);
      `CHK(auto, 8'h0)
      for (i = 0; i < 8; i = i + 1)
      begin
         raw(16'h2 << 2*i, 16'h0);
         chk_ch(i, 1'h1);
      end
      `CHK(lcount, 5'h8)
      for (i = 0; i < 8; i = i + 1)
      begin
         raddr = i[3:0];
         tick(1);
         `CHK(lstate, (8'h2 << i) - 8'h1)
         // Commands were issued three cycles apart
         if (i > 0)
            `CHK(ltime - lt_prev, 32'h3)
         lt_prev = ltime;
      end
      raw(16'h0001, 16'hAAAA);
      `CHK(relay, 8'hFE)
      raw(16'h0, 16'h5555);
      `CHK(relay, 8'h00)
      setup(2, `PCSC_SRC_TTL, 1'h1, 16'h0, 16'h0, 16'h0);
      setup(6, `PCSC_SRC_CLOCK, 1'h1, 16'h0, 16'h0, 16'h0);
      `CHK(auto, 8'h44)
      sens[2] = 1'h1;
      clk_src[6] = 1'h1;
      tick(6);
      `CHK(relay, 8'h44)
      sens[2] = 1'h0;
      clk_src[6] = 1'h0;
      tick(6);
      `CHK(relay, 8'h00)
      meas[63:48] = 16'h00C8;
      setup(3, `PCSC_SRC_ANALOG, 1'h0, 16'h0064, 16'h000A, 16'h0);
      mstep(3, 16'h005A, 1'h1);
      mstep(3, 16'h0069, 1'h1);
      mstep(3, 16'h0078, 1'h0);
      bad[3] = 1'h1;
      fb[3] = 1'h1;
      mstep(3, 16'h0078, 1'h1);
      bad[3] = 1'h0;
      mstep(3, 16'h0078, 1'h0);
      meas[79:64] = 16'h00C8;
      setup(4, `PCSC_SRC_PRESS, 1'h0, 16'h0064, 16'h0, 16'h0002);
      mstep(4, 16'h005A, 1'h0);
      tick(16);
      chk_ch(4, 1'h1);
      mstep(4, 16'h00C8, 1'h1);
      tick(16);
      chk_ch(4, 1'h0);
      meas[95:80] = 16'h00C8;
      part[5] = 1'h1;
      setup(5, `PCSC_SRC_PRESS, 1'h0, 16'h0064, 16'h0, 16'h0);
      for (i = 0; i < 3; i = i + 1)
      begin
         {scan, degas, emis} = 3'h1 << i;
         mstep(5, 16'h0032, 1'h0);
         {scan, degas, emis} = 3'h0;
         tick(4);
         chk_ch(5, 1'h1);
         mstep(5, 16'h00C8, 1'h0);
      end
      for (i = 0; i < 7; i = i + 1)
      begin
         rin_n = ~(7'h1 << i);
         tick(2);
         `CHK(rc, (i == 6) ? 6'h20 : (i == 5) ? 6'h0 : 6'h1 << i)
      end
      rin_n = 7'h7F;
      `CHK(lcount, 5'h0)
      end_of_test;
   end
endmodule // test_pcsc_top
